// ==== hw/sesb_pkg.sv ====
package sesb_pkg;
  localparam int unsigned MCLK_HZ = 250_000_000;
  localparam int unsigned EV_W = 8;
  // event bit positions
  localparam int unsigned BIT_OPC = 0;
  localparam int unsigned BIT_QUERY = 2;
  localparam int unsigned BIT_DEVICE = 3;
  localparam int unsigned BIT_EXEC = 4;
  localparam int unsigned BIT_CMD = 5;
  localparam logic [7:0] EV_USED_MASK = 8'h3d;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam int unsigned SUMMARY_BIT = 5;
  // error class codes, hundreds digit minus one
  localparam logic [1:0] ERR_CMD = 2'h0;
  localparam logic [1:0] ERR_EXEC = 2'h1;
  localparam logic [1:0] ERR_DEVICE = 2'h2;
  localparam logic [1:0] ERR_QUERY = 2'h3;
  localparam int unsigned QUEUE_DEPTH = 8;
  localparam int unsigned QPTR_W = 3;
  typedef enum logic [1:0] {
    OPC_IDLE = 2'b00,
    OPC_ARMED = 2'b01
  } sesb_opc_t;
endpackage : sesb_pkg

// ==== hw/sesb_queue_if.sv ====
`timescale 1ns/1ps
interface sesb_queue_if;
  logic push;
  logic [15:0] push_code;
  logic pop;
  logic flush;
  logic [15:0] head_code;
  logic nonempty;
  modport owner (output push, push_code, pop, flush,
                 input head_code, nonempty);
  modport store (input push, push_code, pop, flush,
                 output head_code, nonempty);
endinterface : sesb_queue_if

// ==== hw/sesb_err_queue.sv ====
`timescale 1ns/1ps
module sesb_err_queue
  import sesb_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  sesb_queue_if.store q
);
  typedef struct packed {
    logic [QPTR_W-1:0] wr;
    logic [QPTR_W-1:0] rd;
    logic [QPTR_W:0] count;
    logic [15:0] head;
  } sesb_q_t;
  logic [15:0] mem [QUEUE_DEPTH];
  sesb_q_t st;
  sesb_q_t next_st;
  logic do_push;
  logic do_pop;
  always_comb begin
    do_push = q.push && !q.flush &&
      (st.count != (QPTR_W+1)'(QUEUE_DEPTH));
    do_pop = q.pop && !q.flush && (st.count != '0);
    next_st = st;
    if (q.flush) begin
      next_st.wr = '0;
      next_st.rd = '0;
      next_st.count = '0;
    end else begin
      if (do_push) next_st.wr = st.wr + QPTR_W'(1);
      if (do_pop) next_st.rd = st.rd + QPTR_W'(1);
      next_st.count = st.count + (QPTR_W+1)'(do_push)
        - (QPTR_W+1)'(do_pop);
    end
    next_st.head = mem[next_st.rd];
    if (do_push && next_st.wr - QPTR_W'(1) == next_st.rd) begin
      next_st.head = q.push_code;
    end
  end
  always_ff @(posedge mclk) begin
    if (do_push) mem[st.wr] <= q.push_code;
    if (!nrst) st <= '0;
    else st <= next_st;
  end
  assign q.head_code = st.head;
  assign q.nonempty = (st.count != '0);
endmodule : sesb_err_queue

// ==== hw/sesb_bank.sv ====
`timescale 1ns/1ps
module sesb_bank
  import sesb_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cls_cmd,
  input wire logic mask_wr,
  input wire logic [7:0] mask_wdata,
  input wire logic mask_rd,
  input wire logic event_rd,
  input wire logic opc_cmd,
  input wire logic work_busy,
  input wire logic err_valid,
  input wire logic [1:0] err_class,
  input wire logic [15:0] err_code,
  input wire logic err_pop,
  input wire logic oper_event,
  input wire logic ques_event,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic summary,
  output logic [7:0] status_byte,
  output logic oper_latch,
  output logic ques_latch,
  output logic [15:0] err_head,
  output logic err_pending
);
  typedef struct packed {
    logic [7:0] event_enable_mask;
    logic [7:0] event_status_latch;
    sesb_opc_t opc;
    logic oper;
    logic ques;
    logic summ;
    logic [7:0] rdata;
    logic rvalid;
    logic [15:0] head;
    logic pend;
  } sesb_st_t;
  sesb_st_t st;
  sesb_st_t next_st;
  logic [7:0] ev_set;
  logic [7:0] ev_now;
  sesb_queue_if qif();
  function automatic logic [7:0] class_bit(input logic [1:0] c);
    logic [7:0] b;
    b = 8'h00;
    case (c)
      ERR_CMD: b[BIT_CMD] = 1'b1;
      ERR_EXEC: b[BIT_EXEC] = 1'b1;
      ERR_DEVICE: b[BIT_DEVICE] = 1'b1;
      ERR_QUERY: b[BIT_QUERY] = 1'b1;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : class_bit
  assign qif.flush = cls_cmd;
  assign qif.push = err_valid;
  assign qif.push_code = err_code;
  assign qif.pop = err_pop;
  sesb_err_queue u_queue (
    .mclk(mclk),
    .nrst(nrst),
    .q(qif.store)
  );
  always_comb begin
    next_st = st;
    ev_set = 8'h00;
    if (err_valid) ev_set = class_bit(err_class);
    if (st.opc == OPC_ARMED && !work_busy && !opc_cmd && !cls_cmd) begin
      ev_set[BIT_OPC] = 1'b1;
      next_st.opc = OPC_IDLE;
    end
    if (opc_cmd) next_st.opc = OPC_ARMED;
    ev_now = st.event_status_latch;
    if (opc_cmd) ev_now[BIT_OPC] = 1'b0;
    // read then clear, mask query wins
    if (event_rd && !mask_rd) ev_now = 8'h00;
    next_st.event_status_latch = (ev_now | ev_set) & EV_USED_MASK;
    next_st.oper = st.oper | oper_event;
    next_st.ques = st.ques | ques_event;
    if (cls_cmd) begin
      next_st.event_status_latch = ev_set & EV_USED_MASK;
      next_st.oper = oper_event;
      next_st.ques = ques_event;
      next_st.opc = opc_cmd ? OPC_ARMED : OPC_IDLE;
    end
    if (mask_wr) next_st.event_enable_mask = mask_wdata;
    next_st.summ = |(next_st.event_status_latch
      & next_st.event_enable_mask & EV_USED_MASK);
    next_st.rvalid = mask_rd | event_rd;
    next_st.rdata = 8'h00;
    if (mask_rd) next_st.rdata = st.event_enable_mask;
    else if (event_rd) next_st.rdata = st.event_status_latch;
    next_st.head = qif.head_code;
    next_st.pend = qif.nonempty;
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st <= '0;
      st.event_enable_mask <= ENABLE_RESET;
      st.event_status_latch <= EVENT_RESET;
      st.opc <= OPC_IDLE;
    end else begin
      st <= next_st;
    end
  end
  assign rdata = st.rdata;
  assign rvalid = st.rvalid;
  assign summary = st.summ;
  assign status_byte = {2'b00, st.summ, 5'b00000};
  assign oper_latch = st.oper;
  assign ques_latch = st.ques;
  assign err_head = st.head;
  assign err_pending = st.pend;
  summary_or_a: assert property (@(posedge mclk) disable iff (!nrst)
    summary == |(st.event_status_latch & st.event_enable_mask))
    else $error("summary differs from masked events");
  unused_bits_a: assert property (@(posedge mclk) disable iff (!nrst)
    (st.event_status_latch & ~EV_USED_MASK) == 8'h00)
    else $error("unused event bit set");
  read_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    event_rd && !mask_rd && !err_valid && !opc_cmd && st.opc == OPC_IDLE |=>
    st.event_status_latch == 8'h00 && rdata == $past(st.event_status_latch))
    else $error("event read did not clear");
  cls_keeps_mask_a: assert property (@(posedge mclk) disable iff (!nrst)
    cls_cmd && !mask_wr |=> $stable(st.event_enable_mask)
    && (st.opc == OPC_IDLE || $past(opc_cmd)))
    else $error("clear-status altered mask");
  cls_flush_a: assert property (@(posedge mclk) disable iff (!nrst)
    cls_cmd |=> ##1 !err_pending)
    else $error("error queue not emptied");
  cmd_class_a: assert property (@(posedge mclk) disable iff (!nrst)
    err_valid && err_class == ERR_CMD && !cls_cmd |=>
    st.event_status_latch[BIT_CMD])
    else $error("command error bit not set");
  opc_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    opc_cmd ##1 work_busy |-> !st.event_status_latch[BIT_OPC])
    else $error("opc bit not cleared");
  mask_query_a: assert property (@(posedge mclk) disable iff (!nrst)
    mask_rd && !mask_wr |=> rvalid && rdata == st.event_enable_mask)
    else $error("mask query wrong");
  mask_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    mask_wr |=> st.event_enable_mask == $past(mask_wdata))
    else $error("mask not stored");
endmodule : sesb_bank

// ==== verification/sesb_ctrl_model.sv ====
`timescale 1ns/1ps
module sesb_ctrl_model (
  input wire logic mclk,
  output logic cls_cmd,
  output logic mask_wr,
  output logic [7:0] mask_wdata,
  output logic mask_rd,
  output logic event_rd,
  output logic opc_cmd,
  output logic err_valid,
  output logic [1:0] err_class,
  output logic [15:0] err_code,
  output logic err_pop
);
  logic [6:0] stb;
  assign {cls_cmd, mask_wr, mask_rd, event_rd, opc_cmd, err_valid,
    err_pop} = stb;
  initial begin
    stb = 7'h00;
    mask_wdata = 8'h00;
    err_class = 2'h0;
    err_code = 16'h0000;
  end
  // one command for one cycle after an optional idle gap
  task automatic send(input logic [6:0] s, input logic [7:0] d,
    input logic [1:0] c, input int gap = 0);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    stb <= s;
    mask_wdata <= d;
    err_class <= c;
    err_code <= 16'(100 * (c + 1));
    @(posedge mclk);
    stb <= 7'h00;
    mask_wdata <= ~d;
    err_code <= 16'hffff;
  endtask : send
endmodule : sesb_ctrl_model

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
  import sesb_pkg::*;
  logic mclk, nrst, work_busy, oper_event, ques_event, cls_cmd, mask_wr;
  logic mask_rd, event_rd, opc_cmd, err_valid, err_pop, rvalid, summary;
  logic oper_latch, ques_latch, err_pending;
  logic [7:0] mask_wdata, rdata, status_byte, mask, ev;
  logic [1:0] err_class, c;
  logic [15:0] err_code, err_head;
  int n_errors, n_compared, seed;
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  sesb_ctrl_model ctl (.mclk(mclk), .cls_cmd(cls_cmd), .mask_wr(mask_wr),
    .mask_wdata(mask_wdata), .mask_rd(mask_rd), .event_rd(event_rd),
    .opc_cmd(opc_cmd), .err_valid(err_valid), .err_class(err_class),
    .err_code(err_code), .err_pop(err_pop));
  sesb_bank DUT (.mclk(mclk), .nrst(nrst), .cls_cmd(cls_cmd),
    .mask_wr(mask_wr), .mask_wdata(mask_wdata), .mask_rd(mask_rd),
    .event_rd(event_rd), .opc_cmd(opc_cmd), .work_busy(work_busy),
    .err_valid(err_valid), .err_class(err_class), .err_code(err_code),
    .err_pop(err_pop), .oper_event(oper_event), .ques_event(ques_event),
    .rdata(rdata), .rvalid(rvalid), .summary(summary),
    .status_byte(status_byte), .oper_latch(oper_latch),
    .ques_latch(ques_latch), .err_head(err_head),
    .err_pending(err_pending));
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask : chk
  function automatic logic [7:0] class_bit(logic [1:0] k);
    return 8'h20 >> k;
  endfunction : class_bit
  task automatic rd(logic [6:0] s, string n, logic [7:0] e);
    ctl.send(s, 8'h00, 2'h0);
    @(negedge mclk);
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    chk(n, {8'h00, e}, {8'h00, rdata});
    @(negedge mclk);
    chk("rvalid drop", 16'h0000, {15'h0000, rvalid});
  endtask : rd
  task automatic stat(logic [7:0] e);
    logic s;
    s = |(e & mask);
    repeat (3) @(negedge mclk);
    chk("summary", {15'h0000, s}, {15'h0000, summary});
    chk("status", {10'h000, s, 5'h00}, {8'h00, status_byte});
  endtask : stat
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    nrst = 1'b0;
    work_busy = 1'b0;
    oper_event = 1'b0;
    ques_event = 1'b0;
    seed = 32'h8e8af7a9;
    mask = 8'h00;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    rd(7'h10, "mask", 8'h00);
    rd(7'h08, "events", 8'h00);
    for (int i = 0; i < 40; i++) begin
      mask = 8'($random(seed));
      if (i == 0) mask = 8'hff;
      if (i == 1) mask = 8'hc2;
      ctl.send(7'h20, mask, 2'h0, i % 3);
      ev = 8'h00;
      repeat (2) begin
        c = 2'($random(seed));
        ctl.send(7'h02, 8'h00, c);
        ev |= class_bit(c);
      end
      stat(ev);
      rd(7'h10, "mask", mask);
      stat(ev);
      rd(7'h08, "events", ev);
      rd(7'h08, "events", 8'h00);
      stat(8'h00);
    end
    $display("test random done");
    mask = 8'h3d;
    ctl.send(7'h20, mask, 2'h0);
    ctl.send(7'h02, 8'h00, 2'h1);
    @(posedge mclk);
    oper_event <= 1'b1;
    ques_event <= 1'b1;
    work_busy <= 1'b1;
    @(posedge mclk);
    oper_event <= 1'b0;
    ques_event <= 1'b0;
    ctl.send(7'h04, 8'h00, 2'h0);
    stat(8'h10);
    chk("pending", 16'h0001, {15'h0000, err_pending});
    chk("oper", 16'h0001, {15'h0000, oper_latch});
    chk("ques", 16'h0001, {15'h0000, ques_latch});
    ctl.send(7'h40, 8'h00, 2'h0);
    work_busy <= 1'b0;
    stat(8'h00);
    chk("oper", 16'h0000, {15'h0000, oper_latch});
    chk("ques", 16'h0000, {15'h0000, ques_latch});
    chk("pending", 16'h0000, {15'h0000, err_pending});
    rd(7'h08, "events", 8'h00);
    rd(7'h10, "mask", 8'h3d);
    ctl.send(7'h02, 8'h00, 2'h3);
    repeat (3) @(negedge mclk);
    chk("head", 16'd400, err_head);
    ctl.send(7'h01, 8'h00, 2'h0);
    repeat (3) @(negedge mclk);
    chk("pending", 16'h0000, {15'h0000, err_pending});
    rd(7'h08, "events", 8'h04);
    $display("test clear done");
    @(posedge mclk);
    work_busy <= 1'b1;
    ctl.send(7'h04, 8'h00, 2'h0);
    rd(7'h08, "events", 8'h00);
    @(posedge mclk);
    work_busy <= 1'b0;
    repeat (3) @(negedge mclk);
    rd(7'h08, "events", 8'h01);
    rd(7'h08, "events", 8'h00);
    $display("test opc done");
    ctl.send(7'h02, 8'h00, 2'h0);
    stat(8'h20);
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    mask = 8'h00;
    stat(8'h00);
    rd(7'h08, "events", 8'h00);
    rd(7'h10, "mask", 8'h00);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : tb
